// *** rtl/regdec_pkg.sv ***
// Shared constants, enumerations and carrier structs for the register access decoder
package regdec_pkg;

    // Configuration header offsets
    localparam logic [7:0] OFF_VID = 8'h00;
    localparam logic [7:0] OFF_DID = 8'h02;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STS = 8'h06;
    localparam logic [7:0] OFF_RID = 8'h08;
    localparam logic [7:0] OFF_CLASS = 8'h09;
    localparam logic [7:0] OFF_LAT = 8'h0d;
    localparam logic [7:0] OFF_HEADER_TYPE = 8'h0e;
    localparam logic [7:0] OFF_HDR_END = 8'h10;
    localparam logic [7:0] OFF_BASE = 8'h20;       // ide_busmaster_io_base (fn 1), usb_io_base (fn 0)
    localparam logic [7:0] OFF_IDE_TIMING = 8'h40;
    localparam logic [7:0] OFF_ISA_IO_RECOVERY_TIMER = 8'h4c;
    localparam logic [7:0] OFF_XBUS_CHIP_SELECT_ENABLE = 8'h4e;
    localparam logic [7:0] OFF_IRQ_ROUTE = 8'h60;
    localparam logic [7:0] OFF_TOM = 8'h69;
    localparam logic [7:0] OFF_MISC_STATUS = 8'h6a;
    localparam logic [7:0] OFF_BOARD_IRQ_ROUTE_0 = 8'h70;
    localparam logic [7:0] OFF_BOARD_IRQ_ROUTE_1 = 8'h71;
    localparam logic [7:0] OFF_MBDMA = 8'h76;
    localparam logic [7:0] OFF_PROGRAMMABLE_CHIP_SELECT_CONTROL = 8'h78;
    localparam logic [7:0] OFF_IOAPIC_BASE_RELOCATION = 8'h80;
    localparam logic [7:0] OFF_DLC = 8'h82;
    localparam logic [7:0] OFF_SMI_CONTROL = 8'ha0;
    localparam logic [7:0] OFF_SMI_ENABLE = 8'ha2;
    localparam logic [7:0] OFF_SEE = 8'ha4;
    localparam logic [7:0] OFF_FAST_OFF_TIMER = 8'ha8;
    localparam logic [7:0] OFF_SMI_REQUEST = 8'haa;

    // Field positions and masks
    localparam int CMD_IO_EN_BIT = 0;              // I/O space enable in the command register
    localparam int ISA_IO_RECOVERY_TIMER_ALIAS_BIT = 2;             // 90-9Fh alias enable in the recovery timer
    localparam logic [7:0] BASE_IO_IND = 8'h01;    // Base register reads back as an I/O base
    localparam logic [7:0] BM_BASE_MASK = 8'hf0;   // 16-byte window
    localparam logic [7:0] USB_BASE_MASK = 8'he0;  // 32-byte window
    localparam logic [7:0] HEADER_TYPE_MULTI = 8'h80;     // Multi-function header type
    localparam logic [7:0] HEADER_TYPE_SINGLE = 8'h00;

    // I/O decode constants
    localparam logic [7:0] IO_RTC_IDX = 8'h70;
    localparam logic [7:0] IO_COPROC = 8'hf0;
    localparam logic [3:0] IO_PAGE_HI = 4'h8;
    localparam logic [3:0] IO_PAGE_ALIAS_HI = 4'h9;
    localparam logic [15:0] POST_NIBBLE_MASK = 16'h7171;  // Low nibbles 0,4-6,8,C-E
    localparam logic [15:0] IO_PM_CNT = 16'h00b2;
    localparam logic [15:0] IO_PM_STS = 16'h00b3;
    localparam logic [15:0] IO_ALIAS_CLR = 16'hffef;

    // Function numbers
    localparam logic [2:0] FN_BRIDGE = 3'h0;
    localparam logic [2:0] FN_IDE = 3'h1;
    localparam logic [2:0] FN_USB = 3'h2;

    // Access kinds on the host side
    typedef enum logic [1:0] {ACC_CFG_RD, ACC_CFG_WR, ACC_IO_RD, ACC_IO_WR} acc_e;

    // Which agent inside the device claimed an access
    typedef enum logic [2:0] {TGT_NONE, TGT_CFG, TGT_LEGACY, TGT_PM, TGT_BMIDE, TGT_USB} tgt_e;

    // Host request
    typedef struct packed {
        acc_e kind;
        logic [2:0] func;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } req_s;

    // Host answer
    typedef struct packed {
        tgt_e tgt;
        logic subtractive;
        logic [31:0] rdata;
    } rsp_s;

    // Single byte cycle toward internal legacy units or the ISA bus
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic [7:0] data;
    } byte_cyc_s;

endpackage

// *** rtl/regdec.sv ***
// Configuration claim, legacy I/O decode and ISA forwarding for the multi-function bridge
// Summary of operation
// - Two-function variant ignores configuration functions 2-7
// - USB variant claims functions 0-2 only
// - Bridge and IDE each own configuration registers
// - Legacy registers live in plain I/O space
// - Positive decode for non-DMA legacy registers
// - Legacy DMA registers claimed subtractively only
// - Only the lowest enabled byte is acted on for legacy and power I/O
// - Upper legacy and power bytes never written; read as zero
// - ISA masters see an 8-bit target
// - Internal hits other than 70h, F0h and listed port-80 family writes are not sent to ISA
// - 70h and F0h reads and writes forwarded
// - Listed port-80 family writes forwarded to ISA
// - Recovery timer bit switches 90-9Fh aliasing
// - Two power registers take byte accesses
// - Other power registers in bridge configuration space
// - Bus-master IDE window of 16 bytes, relocatable
// - IDE window takes byte, word, dword accesses
// - USB block I/O mapped, base in function 0
// - Reserved configuration offsets still complete normally
// - Write-one-to-clear status bits; zero leaves them
`timescale 1ns/100ps
`default_nettype none

module regdec
    import regdec_pkg::*;
#(
    parameter bit USB_PRESENT = 1'b1,              // Variant with the USB function
    parameter logic [15:0] VENDOR_ID = 16'h1a2b,   // Arbitrary value
    parameter logic [15:0] DEVICE_ID0 = 16'h0101,  // Arbitrary value
    parameter logic [15:0] DEVICE_ID1 = 16'h0102,  // Arbitrary value
    parameter logic [15:0] DEVICE_ID2 = 16'h0103,  // Arbitrary value
    parameter logic [7:0] REVISION_ID = 8'h00,     // Arbitrary value
    parameter logic [23:0] CLASS0 = 24'h060100,    // ISA bridge
    parameter logic [23:0] CLASS1 = 24'h010180,    // IDE controller
    parameter logic [23:0] CLASS2 = 24'h0c0300     // USB host controller
)(
    input wire logic clk,                  // 25 MHz clock
    input wire logic rstn,                 // Asynchronous reset, active low
    input wire logic req_valid,            // Host request strobe
    input wire req_s req,                  // Host request
    input wire logic [15:0] sts_set0,      // Status events for function 0
    input wire logic [15:0] sts_set1,      // Status events for function 1
    input wire logic isa_req,              // ISA master I/O request
    input wire logic [15:0] isa_addr,      // ISA master address
    input wire logic isa_wr,               // ISA master write
    input wire logic [7:0] isa_wdata,      // ISA master write byte
    input wire logic [7:0] leg_rdata,      // Read byte from internal legacy units
    output logic isa_ready,                // ISA request accepted this cycle
    output logic isa_ack,                  // ISA master answer
    output logic [7:0] isa_rdata,          // ISA master read byte
    output logic rsp_valid,                // Host answer strobe
    output rsp_s rsp,                      // Host answer
    output logic leg_valid,                // Byte cycle to internal legacy units
    output byte_cyc_s leg,                 // Legacy byte cycle
    output logic fwd_valid,                // Byte cycle broadcast on ISA
    output byte_cyc_s fwd,                 // Forwarded byte cycle
    output logic [7:0] pm_ctrl,            // Power I/O register 0
    output logic [7:0] pm_stat,            // Power I/O register 1
    output logic alias_en                  // 90-9Fh alias active
);

    // Complete module state
    typedef struct packed {
        logic [255:0][7:0] f0;       // Bridge configuration bytes
        logic [255:0][7:0] f1;       // IDE configuration bytes
        logic [15:0][7:0] bm;        // Bus-master IDE window
        logic [1:0][7:0] pm;         // Power I/O bytes
        logic s1_valid;              // Stage 1 holds an access
        logic s1_isa;                // Stage 1 came from an ISA master
        logic s1_leg_rd;             // Stage 1 waits for legacy read data
        logic [1:0] s1_lane;         // Lane that carries the legacy byte
        tgt_e s1_tgt;
        logic s1_sub;
        logic [31:0] s1_rdata;
        logic leg_valid;
        byte_cyc_s leg;
        logic fwd_valid;
        byte_cyc_s fwd;
        logic rsp_valid;
        rsp_s rsp;
        logic isa_ack;
        logic [7:0] isa_rdata;
    } st_s;

    st_s s_q;
    st_s s_d;

    // Lowest enabled lane of a byte-enable group
    function automatic logic [1:0] low_lane(input logic [3:0] be);
        low_lane = 2'd0;
        for (int i = 3; i >= 0; i--)
        begin
            if (be[i])
            begin
                low_lane = 2'(i);
            end
        end
    endfunction

    // True when off lies in [base, base+n)
    function automatic logic in_reg(input logic [7:0] off, input logic [7:0] base, input int n);
        in_reg = ({1'b0, off} >= {1'b0, base}) && ({1'b0, off} < 9'({1'b0, base} + 9'(n)));
    endfunction

    // Writable bits of a configuration byte
    function automatic logic [7:0] wmask(input logic [2:0] fn, input logic [7:0] off);
        wmask = 8'h00;
        if (in_reg(off, OFF_CMD, 2))
        begin
            wmask = 8'hff;
        end
        else if (off == OFF_BASE)
        begin
            wmask = (fn == FN_IDE) ? BM_BASE_MASK : USB_BASE_MASK;
        end
        else if (in_reg(off, OFF_BASE + 8'h01, 3))
        begin
            wmask = 8'hff;
        end
        else if (fn == FN_IDE)
        begin
            // IDE timing and latency timer
            if (in_reg(off, OFF_IDE_TIMING, 5) || off == OFF_LAT)
            begin
                wmask = 8'hff;
            end
        end
        else if (in_reg(off, OFF_ISA_IO_RECOVERY_TIMER, 1) || in_reg(off, OFF_XBUS_CHIP_SELECT_ENABLE, 2) || in_reg(off, OFF_IRQ_ROUTE, 4) ||
                 in_reg(off, OFF_TOM, 1) || in_reg(off, OFF_MISC_STATUS, 2) || in_reg(off, OFF_BOARD_IRQ_ROUTE_0, 1) ||
                 in_reg(off, OFF_BOARD_IRQ_ROUTE_1, 1) || in_reg(off, OFF_MBDMA, 2) || in_reg(off, OFF_PROGRAMMABLE_CHIP_SELECT_CONTROL, 2) ||
                 in_reg(off, OFF_IOAPIC_BASE_RELOCATION, 1) || in_reg(off, OFF_DLC, 1))
        begin
            wmask = 8'hff;
        end
        else if (in_reg(off, OFF_SMI_CONTROL, 1) || in_reg(off, OFF_SMI_ENABLE, 2) || in_reg(off, OFF_SEE, 4) ||
                 in_reg(off, OFF_FAST_OFF_TIMER, 1) || in_reg(off, OFF_SMI_REQUEST, 2))
        begin
            wmask = 8'hff;
        end
    endfunction

    // Read-only identity bytes of the header
    function automatic logic [7:0] id_byte(input logic [2:0] fn, input logic [7:0] off);
        logic [15:0] device_identifier;
        logic [23:0] cls;
        device_identifier = (fn == FN_BRIDGE) ? DEVICE_ID0 : ((fn == FN_IDE) ? DEVICE_ID1 : DEVICE_ID2);
        cls = (fn == FN_BRIDGE) ? CLASS0 : ((fn == FN_IDE) ? CLASS1 : CLASS2);
        id_byte = 8'h00;
        if (off == OFF_VID)
        begin
            id_byte = VENDOR_ID[7:0];
        end
        else if (off == OFF_VID + 8'h01)
        begin
            id_byte = VENDOR_ID[15:8];
        end
        else if (off == OFF_DID)
        begin
            id_byte = device_identifier[7:0];
        end
        else if (off == OFF_DID + 8'h01)
        begin
            id_byte = device_identifier[15:8];
        end
        else if (off == OFF_RID)
        begin
            id_byte = REVISION_ID;
        end
        else if (in_reg(off, OFF_CLASS, 3))
        begin
            id_byte = cls[8 * (off - OFF_CLASS) +: 8];
        end
        else if (off == OFF_HEADER_TYPE)
        begin
            id_byte = (fn == FN_BRIDGE) ? HEADER_TYPE_MULTI : HEADER_TYPE_SINGLE;
        end
    endfunction

    // Positively decoded legacy addresses (timer, interrupt, X-bus, NMI, RTC, coprocessor)
    function automatic logic is_legacy(input logic [15:0] a);
        is_legacy = (a[15:8] == 8'h00) &&
                    ((a[7:1] == 7'h10) || (a[7:1] == 7'h50) || (a[7:2] == 6'h10) ||
                     (a[7:1] == 7'h30) || (a[7:0] == IO_RTC_IDX) || (a[7:0] == IO_COPROC));
    endfunction

    // Legacy DMA addresses, including the page block and its alias
    function automatic logic is_dma(input logic [15:0] a, input logic al);
        is_dma = (a[15:8] == 8'h00) &&
                 ((a[7:4] == 4'h0) || (a[7:4] == IO_PAGE_HI) || (a[7:5] == 3'h6) ||
                  (al && a[7:4] == IO_PAGE_ALIAS_HI));
    endfunction

    // Writes that are also broadcast on ISA
    function automatic logic is_post_wr(input logic [15:0] a, input logic al);
        is_post_wr = (a[15:8] == 8'h00) && POST_NIBBLE_MASK[a[3:0]] &&
                     ((a[7:4] == IO_PAGE_HI) || (al && a[7:4] == IO_PAGE_ALIAS_HI));
    endfunction

    // Decode, register update and two-stage answer
    always_comb
    begin
        logic [7:0] off;
        logic [7:0] wb;
        logic [7:0] m;
        logic [1:0] lane;
        logic [15:0] ba;
        logic [15:0] bm_base;
        logic [15:0] usb_base;
        logic al;
        logic is_wr;
        off = 8'h00;
        wb = 8'h00;
        m = 8'h00;
        lane = 2'd0;
        ba = 16'h0000;
        s_d = s_q;
        al = s_q.f0[OFF_ISA_IO_RECOVERY_TIMER][ISA_IO_RECOVERY_TIMER_ALIAS_BIT];
        bm_base = {s_q.f1[OFF_BASE + 8'h01], s_q.f1[OFF_BASE] & BM_BASE_MASK};
        usb_base = {s_q.f0[OFF_BASE + 8'h01], s_q.f0[OFF_BASE] & USB_BASE_MASK};
        is_wr = (req.kind == ACC_IO_WR);

        // Stage 2: answers one cycle after stage 1
        s_d.rsp_valid = s_q.s1_valid && !s_q.s1_isa;
        s_d.rsp.tgt = s_q.s1_tgt;
        s_d.rsp.subtractive = s_q.s1_sub;
        s_d.rsp.rdata = s_q.s1_rdata;
        if (s_q.s1_leg_rd)
        begin
            s_d.rsp.rdata = 32'h0000_0000;
            s_d.rsp.rdata[8 * s_q.s1_lane +: 8] = leg_rdata;
        end
        s_d.isa_ack = s_q.s1_valid && s_q.s1_isa;
        s_d.isa_rdata = s_q.s1_leg_rd ? leg_rdata : 8'h00;

        // Stage 1 defaults
        s_d.s1_valid = 1'b0;
        s_d.s1_isa = 1'b0;
        s_d.s1_leg_rd = 1'b0;
        s_d.s1_lane = 2'd0;
        s_d.s1_tgt = TGT_NONE;
        s_d.s1_sub = 1'b0;
        s_d.s1_rdata = 32'h0000_0000;
        s_d.leg_valid = 1'b0;
        s_d.fwd_valid = 1'b0;

        if (req_valid && (req.kind == ACC_CFG_RD || req.kind == ACC_CFG_WR))
        begin
            s_d.s1_valid = 1'b1;
            // Claim functions 0 and 1, and 2 only with USB fitted
            if (req.func == FN_BRIDGE || req.func == FN_IDE || (USB_PRESENT && req.func == FN_USB))
            begin
                s_d.s1_tgt = TGT_CFG;
            end
            for (int i = 0; i < 4; i++)
            begin
                off = {req.addr[7:2], 2'(i)};
                // Read side: header identity, else the function's own bytes
                if (off < OFF_HDR_END && !in_reg(off, OFF_CMD, 4) && !(req.func == FN_IDE && off == OFF_LAT))
                begin
                    s_d.s1_rdata[8 * i +: 8] = id_byte(req.func, off);
                end
                else if (req.func == FN_BRIDGE)
                begin
                    s_d.s1_rdata[8 * i +: 8] = s_q.f0[off] | ((off == OFF_BASE) ? BASE_IO_IND : 8'h00);
                end
                else if (req.func == FN_IDE)
                begin
                    s_d.s1_rdata[8 * i +: 8] = s_q.f1[off] | ((off == OFF_BASE) ? BASE_IO_IND : 8'h00);
                end
                // Write side: separate register sets per function
                if (req.kind == ACC_CFG_WR && req.be[i])
                begin
                    wb = req.wdata[8 * i +: 8];
                    m = wmask(req.func, off);
                    if (in_reg(off, OFF_STS, 2))
                    begin
                        // Ones clear, zeros keep
                        if (req.func == FN_BRIDGE)
                        begin
                            s_d.f0[off] = s_q.f0[off] & ~wb;
                        end
                        else if (req.func == FN_IDE)
                        begin
                            s_d.f1[off] = s_q.f1[off] & ~wb;
                        end
                    end
                    else if (req.func == FN_BRIDGE)
                    begin
                        s_d.f0[off] = (s_q.f0[off] & ~m) | (wb & m);
                    end
                    else if (req.func == FN_IDE)
                    begin
                        s_d.f1[off] = (s_q.f1[off] & ~m) | (wb & m);
                    end
                end
            end
        end
        else if (req_valid)
        begin
            // I/O space access from the host
            s_d.s1_valid = 1'b1;
            lane = low_lane(req.be);
            ba = {req.addr[15:2], lane};
            if (s_q.f1[OFF_CMD][CMD_IO_EN_BIT] && req.addr[15:4] == bm_base[15:4])
            begin
                // Bus-master IDE window, any width
                s_d.s1_tgt = TGT_BMIDE;
                for (int i = 0; i < 4; i++)
                begin
                    off = {4'h0, req.addr[3:2], 2'(i)};
                    s_d.s1_rdata[8 * i +: 8] = s_q.bm[off[3:0]];
                    if (is_wr && req.be[i])
                    begin
                        s_d.bm[off[3:0]] = req.wdata[8 * i +: 8];
                    end
                end
            end
            else if (USB_PRESENT && s_q.f0[OFF_CMD][CMD_IO_EN_BIT] && req.addr[15:5] == usb_base[15:5])
            begin
                // USB block claims; its registers live in the host controller
                s_d.s1_tgt = TGT_USB;
            end
            else if (ba == IO_PM_CNT || ba == IO_PM_STS)
            begin
                // Power byte registers
                s_d.s1_tgt = TGT_PM;
                s_d.s1_rdata[8 * lane +: 8] = s_q.pm[ba[0]];
                if (is_wr && req.be != 4'h0)
                begin
                    s_d.pm[ba[0]] = req.wdata[8 * lane +: 8];
                end
            end
            else if (is_legacy(ba) || is_dma(ba, al))
            begin
                // Legacy registers reached through I/O space
                s_d.s1_tgt = TGT_LEGACY;
                s_d.s1_sub = !is_legacy(ba);
                s_d.s1_lane = lane;
                s_d.s1_leg_rd = !is_wr;
                s_d.leg_valid = 1'b1;
                s_d.leg.addr = (al && ba[7:4] == IO_PAGE_ALIAS_HI) ? (ba & IO_ALIAS_CLR) : ba;
                s_d.leg.wr = is_wr;
                s_d.leg.data = req.wdata[8 * lane +: 8];
                // Only listed ports also reach ISA
                if (ba[7:0] == IO_RTC_IDX || ba[7:0] == IO_COPROC || (is_wr && is_post_wr(ba, al)))
                begin
                    s_d.fwd_valid = 1'b1;
                end
                s_d.fwd.addr = ba;
                s_d.fwd.wr = is_wr;
                s_d.fwd.data = req.wdata[8 * lane +: 8];
            end
        end
        else if (isa_req)
        begin
            // ISA master byte cycle, already on the ISA bus
            s_d.s1_valid = 1'b1;
            s_d.s1_isa = 1'b1;
            if (is_legacy(isa_addr) || is_dma(isa_addr, al))
            begin
                s_d.s1_tgt = TGT_LEGACY;
                s_d.s1_leg_rd = !isa_wr;
                s_d.leg_valid = 1'b1;
                s_d.leg.addr = (al && isa_addr[7:4] == IO_PAGE_ALIAS_HI) ? (isa_addr & IO_ALIAS_CLR) : isa_addr;
                s_d.leg.wr = isa_wr;
                s_d.leg.data = isa_wdata;
            end
        end

        // Hardware status events win over a clear in the same cycle
        s_d.f0[OFF_STS] = s_d.f0[OFF_STS] | sts_set0[7:0];
        s_d.f0[OFF_STS + 8'h01] = s_d.f0[OFF_STS + 8'h01] | sts_set0[15:8];
        s_d.f1[OFF_STS] = s_d.f1[OFF_STS] | sts_set1[7:0];
        s_d.f1[OFF_STS + 8'h01] = s_d.f1[OFF_STS + 8'h01] | sts_set1[15:8];
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign isa_ready = isa_req && !req_valid;
    assign isa_ack = s_q.isa_ack;
    assign isa_rdata = s_q.isa_rdata;
    assign rsp_valid = s_q.rsp_valid;
    assign rsp = s_q.rsp;
    assign leg_valid = s_q.leg_valid;
    assign leg = s_q.leg;
    assign fwd_valid = s_q.fwd_valid;
    assign fwd = s_q.fwd;
    assign pm_ctrl = s_q.pm[0];
    assign pm_stat = s_q.pm[1];
    assign alias_en = s_q.f0[OFF_ISA_IO_RECOVERY_TIMER][ISA_IO_RECOVERY_TIMER_ALIAS_BIT];

endmodule
`default_nettype wire

// *** testbench/regdec_properties.sv ***
// Port checker for the register access decoder
`timescale 1ns/100ps
`default_nettype none
module regdec_properties
    import regdec_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic req_valid, // Host strobe
    input wire req_s req, // Host request
    input wire logic isa_ready, // ISA taken
    input wire logic isa_ack, // ISA answer
    input wire logic rsp_valid, // Host answer strobe
    input wire rsp_s rsp, // Host answer
    input wire logic fwd_valid // ISA broadcast
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Kind bit 1 marks I/O requests
    wire logic io = req_valid && req.kind[1] && req.be[0];
    wire logic cf = req_valid && !req.kind[1];
    // Answer two edges after a taken request
    sequence s_ans; ##2 rsp_valid; endsequence
    property p_cfg; cf && req.func < 3'h2 |-> s_ans ##0 rsp.tgt == TGT_CFG; endproperty
    property p_fnhi; cf && req.func > 3'h2 |-> s_ans ##0 rsp.tgt == TGT_NONE; endproperty
    property p_isa; isa_ready |-> ##2 isa_ack; endproperty
    property p_rtc; io && req.addr == 16'h0070 |=> fwd_valid; endproperty
    property p_rd8x; req_valid && req.kind == ACC_IO_RD && req.addr[15:4] == 12'h008 |=> !fwd_valid; endproperty
    property p_isafw; isa_ready |=> !fwd_valid; endproperty
    property p_dma; io && req.addr[15:4] == 12'h000 |-> s_ans ##0 rsp.subtractive; endproperty
    property p_pos; io && req.addr == 16'h0040 |-> s_ans ##0 rsp.tgt == TGT_LEGACY && !rsp.subtractive; endproperty
    a_cfg: assert property (p_cfg) else $error("cfg claim wrong");
    a_fnhi: assert property (p_fnhi) else $error("high function claimed");
    a_isa: assert property (p_isa) else $error("isa ack late");
    a_rtc: assert property (p_rtc) else $error("70h not broadcast");
    a_rd8x: assert property (p_rd8x) else $error("8xh read broadcast");
    a_isafw: assert property (p_isafw) else $error("isa cycle broadcast");
    a_dma: assert property (p_dma) else $error("dma not subtractive");
    a_pos: assert property (p_pos) else $error("timer not positive");
endmodule
bind regdec regdec_properties i_regdec_properties (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .isa_ready(isa_ready), .isa_ack(isa_ack), .rsp_valid(rsp_valid), .rsp(rsp), .fwd_valid(fwd_valid));
`default_nettype wire

// *** testbench/legacy_unit.sv ***
// Model of the internal legacy units answering byte reads
`timescale 1ns/100ps
`default_nettype none
module legacy_unit
    import regdec_pkg::*;
(
    input wire logic leg_valid, // Byte cycle strobe
    input wire byte_cyc_s leg, // Byte cycle
    output logic [7:0] leg_rdata // Read byte
);
    // Address-derived byte while selected, its inverse otherwise
    always_comb
        leg_rdata = leg_valid ? leg.addr[7:0] ^ 8'h5a : ~(leg.addr[7:0] ^ 8'h5a);
endmodule
`default_nettype wire

// *** testbench/regdec_tb.sv ***
// Self-checking bench for the register access decoder
`timescale 1ns/100ps
`default_nettype none
module regdec_tb;
    import regdec_pkg::*;
    localparam logic [15:0] ID_VAL = 16'h5c3d; // Arbitrary value
    logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, isa_req = 1'b0, isa_wr = 1'b0, fv;
    req_s req = '0;
    logic [15:0] sts_set1 = '0, isa_addr = '0;
    logic [7:0] leg_rdata, isa_rdata, pm_ctrl;
    logic isa_ready, isa_ack, rsp_valid, leg_valid, fwd_valid, alias_en;
    rsp_s rsp, r;
    byte_cyc_s leg, fwd, fw;
    int errors = 0, n_checks = 0;
    regdec #(.VENDOR_ID(ID_VAL)) i_regdec (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
        .sts_set0(16'h0000), .sts_set1(sts_set1), .isa_req(isa_req), .isa_addr(isa_addr), .isa_wr(isa_wr),
        .isa_wdata(8'h00), .leg_rdata(leg_rdata), .isa_ready(isa_ready), .isa_ack(isa_ack),
        .isa_rdata(isa_rdata), .rsp_valid(rsp_valid), .rsp(rsp), .leg_valid(leg_valid), .leg(leg),
        .fwd_valid(fwd_valid), .fwd(fwd), .pm_ctrl(pm_ctrl), .pm_stat(), .alias_en(alias_en));
    legacy_unit i_legacy_unit (.leg_valid(leg_valid), .leg(leg), .leg_rdata(leg_rdata));
    initial forever #20 clk = ~clk;
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One host transfer: broadcast kept in fv/fw, answer in r
    task automatic host(input acc_e k, input logic [2:0] f, input logic [15:0] a, input logic [3:0] be,
        input logic [31:0] d);
        req_valid = 1'b1;
        req = '{k, f, a, be, d};
        @(posedge clk) #1 req_valid = 1'b0;
        fv = fwd_valid;
        fw = fwd;
        @(posedge clk) #1 chk(rsp_valid, 1'b1);
        r = rsp;
    endtask
    // Claims, identity, reserved offset, status clearing
    task automatic t_cfg();
        host(ACC_CFG_RD, FN_IDE, 16'h0000, 4'hf, '0);
        chk(r.rdata[15:0], ID_VAL);
        for (int f = 3; f < 8; f++)
        begin
            host(ACC_CFG_RD, 3'(f), 16'h0000, 4'hf, '0);
            chk(r.tgt, TGT_NONE);
        end
        host(ACC_CFG_RD, FN_USB, 16'h0000, 4'hf, '0);
        chk(r.tgt, TGT_CFG);
        host(ACC_CFG_WR, FN_BRIDGE, 16'h000c, 4'h1, '1);
        host(ACC_CFG_RD, FN_BRIDGE, 16'h000c, 4'hf, '0);
        chk({r.tgt, r.rdata[7:0]}, {TGT_CFG, 8'h00});
        sts_set1 = 16'h0900;
        @(posedge clk) #1 sts_set1 = '0;
        host(ACC_CFG_WR, FN_IDE, 16'h0004, 4'hc, 32'h0100_0000);
        host(ACC_CFG_RD, FN_IDE, 16'h0004, 4'hf, '0);
        chk(r.rdata[31:16], 16'h0800);
    endtask
    // Lowest lane, broadcast, decode kinds, aliasing, power byte
    task automatic t_leg();
        host(ACC_IO_WR, FN_BRIDGE, 16'h0080, 4'hf, 32'h1122_3344);
        chk({fv, fw}, {1'b1, 16'h0080, 1'b1, 8'h44});
        chk({r.tgt, r.subtractive}, {TGT_LEGACY, 1'b1});
        host(ACC_IO_RD, FN_BRIDGE, 16'h0084, 4'h1, '0);
        chk({fv, r.subtractive, r.rdata[15:0]}, {1'b0, 1'b1, 16'h00de});
        host(ACC_IO_WR, FN_BRIDGE, 16'h0008, 4'h1, 32'h7);
        chk({fv, r.tgt, r.subtractive}, {1'b0, TGT_LEGACY, 1'b1});
        host(ACC_IO_RD, FN_BRIDGE, 16'h0070, 4'h1, '0);
        chk({fv, r.rdata[7:0]}, {1'b1, 8'h2a});
        host(ACC_IO_WR, FN_BRIDGE, 16'h0040, 4'h1, 32'h5);
        chk({fv, r.tgt, r.subtractive}, {1'b0, TGT_LEGACY, 1'b0});
        host(ACC_IO_RD, FN_BRIDGE, 16'h0090, 4'h1, '0);
        chk(r.tgt, TGT_NONE);
        host(ACC_CFG_WR, FN_BRIDGE, 16'h004c, 4'h1, 32'h4);
        host(ACC_IO_RD, FN_BRIDGE, 16'h0090, 4'h1, '0);
        chk({alias_en, r.tgt}, {1'b1, TGT_LEGACY});
        chk(leg.addr, 16'h0080);
        host(ACC_IO_WR, FN_BRIDGE, 16'h00b0, 4'h4, 32'h00ab_0000);
        chk({r.tgt, pm_ctrl}, {TGT_PM, 8'hab});
    endtask
    // Bus-master window placed at E0h and enabled
    task automatic t_bm();
        host(ACC_CFG_WR, FN_IDE, 16'h0020, 4'hf, 32'h0000_00e0);
        host(ACC_CFG_WR, FN_IDE, 16'h0004, 4'h3, 32'h1);
        host(ACC_CFG_RD, FN_IDE, 16'h0020, 4'hf, '0);
        chk(r.rdata[7:0], 8'he1);
        host(ACC_IO_WR, FN_BRIDGE, 16'h00ec, 4'hf, '1);
        chk(r.tgt, TGT_BMIDE);
        host(ACC_IO_RD, FN_BRIDGE, 16'h00ec, 4'h1, '0);
        chk(r.rdata, 32'hffff_ffff);
        host(ACC_IO_RD, FN_BRIDGE, 16'h00f0, 4'h1, '0);
        chk(r.tgt, TGT_LEGACY);
    endtask
    // ISA master byte read of 61h
    task automatic t_isa();
        isa_req = 1'b1;
        isa_addr = 16'h0061;
        @(posedge clk) #1 isa_req = 1'b0;
        @(posedge clk) #1 chk({isa_ack, isa_rdata}, {1'b1, 8'h3b});
    endtask
    // Reset, then scenarios
    initial
    begin
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        t_cfg();
        t_leg();
        t_bm();
        t_isa();
        close_out();
    end
endmodule
`default_nettype wire
